// ### core/page_program_status_pkg.sv
// Constants and types for the page programming status block
// =====================================================================
// What this block does
// [R1] Each loaded data byte advances the in-page byte pointer by one.
// [R2] Pointer past the last page byte wraps to the first byte of the page.
// [R3] Programmer must never load the same buffer location twice per load.
// [R4] Load flag (bit 3) clears on load command, sets on next memory write.
// [R5] Success flag (bit 2) clears at cycle start, sets on clean completion.
// [R6] Write inhibit flag (bit 1) goes low while brown-out blocks programming.
// [R7] A brown-out anywhere during a cycle keeps success low afterwards.
// [R8] Write inhibit low forces the busy flag low too.
// [R9] Busy flag (bit 0) is low while programming, erasing or inhibited, else high.
// [R10] Polling the last byte while busy returns it with its top bit inverted.
// [R11] Polling during erase returns all ones with the top bit cleared.
// [R12] The polled byte is the last byte loaded, not the highest address.
// [R13] Status bits 7..4 read zero; writes to the status register do nothing.
// [R14] The status register is readable at any time, even while busy.
package page_program_status_pkg;
  localparam int          ADDR_W           = 5;
  localparam logic [4:0]  ADDR_FLAGS       = 5'h00;
  localparam logic [4:0]  ADDR_COMMAND     = 5'h04;
  localparam logic [4:0]  ADDR_DATA        = 5'h08;
  localparam logic [4:0]  ADDR_POINTER     = 5'h0c;
  localparam logic [4:0]  ADDR_BUFFER      = 5'h10;
  localparam int          BIT_BUSY_N       = 0;
  localparam int          BIT_WRITE_INHIBIT = 1;
  localparam int          BIT_SUCCESS      = 2;
  localparam int          BIT_LOAD         = 3;
  localparam int          CMD_LOAD_BUFFER  = 0;
  localparam int          CMD_PROGRAM      = 1;
  localparam int          CMD_ERASE        = 2;
  localparam logic        LOAD_RESET       = 1'b1;
  localparam logic        SUCCESS_RESET    = 1'b0;
  localparam int          PAGE_BYTES       = 64;
  localparam int          PTR_W            = 6;
  localparam logic [5:0]  PTR_RESET        = 6'h00;
  localparam logic [5:0]  PTR_LAST         = 6'h3f;
  localparam logic [7:0]  DATA_RESET       = 8'hff;
  localparam logic [7:0]  ERASE_VALUE      = 8'hff;
  localparam logic [7:0]  POLL_MASK        = 8'h80;
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          PROG_TIME_US     = 2500;
  localparam int          PROG_CYCLES      = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          CNT_W            = 20;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_ERASE   = 3'b100
  } prog_state_type;
endpackage

// ### core/page_buffer.sv
// Page buffer storage with auto-incrementing, wrapping byte pointer
`timescale 1ns/10ps
module page_buffer
  import page_program_status_pkg::*;
(
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic                                  set_ptr,
  input  wire logic [page_program_status_pkg::PTR_W-1:0] set_value,
  input  wire logic                                  write_en,
  input  wire logic [7:0]                            write_data,
  output logic      [page_program_status_pkg::PTR_W-1:0] ptr,
  output logic      [7:0]                            read_data
);
  logic [PTR_W-1:0] next_ptr;
  logic [7:0]       entry      [PAGE_BYTES];
  logic [7:0]       next_entry [PAGE_BYTES];

  // =====================================================================
  // Storage
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_entry
    assign next_entry[i] = (write_en && ptr == PTR_W'(i)) ? write_data : entry[i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        entry[i] <= DATA_RESET;
      end else begin
        entry[i] <= next_entry[i];
      end
    end
  end
  assign read_data = entry[ptr];

  // =====================================================================
  // Pointer
  always_comb begin
    next_ptr = ptr;
    if (set_ptr) begin
      next_ptr = set_value;
    end else if (write_en) begin
      next_ptr = (ptr == PTR_LAST) ? PTR_RESET : ptr + 1'b1; // [R1] [R2]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= PTR_RESET;
    end else begin
      ptr <= next_ptr;
    end
  end
endmodule

// ### core/page_program_status.sv
// Page load, programming sequencer and status register behind AXI4-Lite
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module page_program_status
  import page_program_status_pkg::*;
#(
  parameter int prog_cycles = page_program_status_pkg::PROG_CYCLES
)(
  input  wire logic                                      aclk,
  input  wire logic                                      aresetn,
  input  wire logic                                      brownout_detector,
  input  wire logic                                      awvalid,
  output logic                                           awready,
  input  wire logic [page_program_status_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                                awprot,
  input  wire logic                                      wvalid,
  output logic                                           wready,
  input  wire logic [31:0]                               wdata,
  input  wire logic [3:0]                                wstrb,
  output logic                                           bvalid,
  input  wire logic                                      bready,
  output logic      [1:0]                                bresp,
  input  wire logic                                      arvalid,
  output logic                                           arready,
  input  wire logic [page_program_status_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                                arprot,
  output logic                                           rvalid,
  input  wire logic                                      rready,
  output logic      [31:0]                               rdata,
  output logic      [1:0]                                rresp
);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(prog_cycles - 1);

  logic             bod_s1, bod_s2, bod_s3, inhibited, next_inhibited;
  logic             aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic [7:0]       wbyte, next_wbyte;
  logic             wlane, next_wlane;
  logic             next_bvalid, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;
  prog_state_type   state, next_state;
  logic [CNT_W-1:0] count, next_count;
  logic             load_flag, next_load_flag, success, next_success;
  logic             bod_seen, next_bod_seen;
  logic [7:0]       last_byte, next_last_byte, poll_byte, flags;
  logic             do_write, cmd_write, idle, load_cmd, start_prog, start_erase;
  logic             data_write, ptr_write, busy, write_inhibit_flag;
  logic [PTR_W-1:0] ptr;
  logic [7:0]       buf_byte;

  // =====================================================================
  // Brown-out input synchroniser and agreement filter
  always_comb begin
    next_inhibited = (bod_s2 == bod_s3) ? bod_s3 : inhibited;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bod_s1    <= 1'b0;
      bod_s2    <= 1'b0;
      bod_s3    <= 1'b0;
      inhibited <= 1'b0;
    end else begin
      bod_s1    <= brownout_detector;
      bod_s2    <= bod_s1;
      bod_s3    <= bod_s2;
      inhibited <= next_inhibited;
    end
  end

  // =====================================================================
  // Decode
  assign idle        = (state == ST_IDLE);
  assign busy        = !idle;
  assign do_write    = aw_held && w_held && !bvalid;
  assign cmd_write   = do_write && waddr == ADDR_COMMAND && wlane && idle;
  assign load_cmd    = cmd_write && wbyte[CMD_LOAD_BUFFER];
  assign start_prog  = cmd_write && !wbyte[CMD_LOAD_BUFFER] && wbyte[CMD_PROGRAM] && !inhibited;
  assign start_erase = cmd_write && !wbyte[CMD_LOAD_BUFFER] && !wbyte[CMD_PROGRAM] && wbyte[CMD_ERASE] &&
                       !inhibited;
  assign data_write  = do_write && waddr == ADDR_DATA && wlane && idle;
  assign ptr_write   = do_write && waddr == ADDR_POINTER && wlane && idle;

  assign write_inhibit_flag = !inhibited;                             // [R6]
  assign flags = {4'h0, load_flag, success, write_inhibit_flag, !(busy || inhibited)}; // [R13] [R8] [R9]

  always_comb begin
    if (state == ST_ERASE) begin
      poll_byte = ERASE_VALUE & ~POLL_MASK;                           // [R11]
    end else if (busy) begin
      poll_byte = last_byte ^ POLL_MASK;                              // [R10]
    end else begin
      poll_byte = last_byte;
    end
  end

  page_buffer page_buffer_inst (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_ptr    (load_cmd || ptr_write),
    .set_value  (ptr_write ? wbyte[PTR_W-1:0] : PTR_RESET),
    .write_en   (data_write),
    .write_data (wbyte),
    .ptr        (ptr),
    .read_data  (buf_byte)
  );

  // =====================================================================
  // Programming sequencer and flags
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_load_flag = load_flag;
    next_success   = success;
    next_bod_seen  = bod_seen;
    next_last_byte = last_byte;
    if (data_write) begin
      next_last_byte = wbyte;                                         // [R12]
    end
    if (load_cmd) begin
      next_load_flag = 1'b0;                                          // [R4]
    end
    case (state)
      ST_IDLE: begin
        if (start_prog || start_erase) begin
          next_state     = start_prog ? ST_PROGRAM : ST_ERASE;
          next_count     = '0;
          next_load_flag = 1'b1;                                      // [R4]
          next_success   = 1'b0;                                      // [R5]
          next_bod_seen  = 1'b0;
          if (start_erase) begin
            next_last_byte = ERASE_VALUE;
          end
        end
      end
      ST_PROGRAM, ST_ERASE: begin
        if (inhibited) begin
          next_bod_seen = 1'b1;                                       // [R7]
        end
        if (count == CNT_LAST) begin
          next_state   = ST_IDLE;
          next_success = !(bod_seen || inhibited);                    // [R5] [R7]
        end else begin
          next_count = count + 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_IDLE;
      count     <= '0;
      load_flag <= LOAD_RESET;
      success   <= SUCCESS_RESET;
      bod_seen  <= 1'b0;
      last_byte <= DATA_RESET;
    end else begin
      state     <= next_state;
      count     <= next_count;
      load_flag <= next_load_flag;
      success   <= next_success;
      bod_seen  <= next_bod_seen;
      last_byte <= next_last_byte;
    end
  end

  // =====================================================================
  // AXI4-Lite slave
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_waddr   = waddr;
    next_wbyte   = wbyte;
    next_wlane   = wlane;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_rvalid  = rvalid && !rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_waddr   = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wbyte  = wdata[7:0];
      next_wlane  = wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (waddr inside {ADDR_FLAGS, ADDR_COMMAND, ADDR_DATA, ADDR_POINTER, ADDR_BUFFER}) ?
                     RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;                                             // [R14]
      next_rresp  = RESP_OKAY;
      case (araddr)
        ADDR_FLAGS:   next_rdata = {24'h0, flags};
        ADDR_COMMAND: next_rdata = 32'h0;
        ADDR_DATA:    next_rdata = {24'h0, poll_byte};
        ADDR_POINTER: next_rdata = {26'h0, ptr};
        ADDR_BUFFER:  next_rdata = {24'h0, buf_byte};
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      waddr   <= '0;
      wbyte   <= 8'h00;
      wlane   <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      waddr   <= next_waddr;
      wbyte   <= next_wbyte;
      wlane   <= next_wlane;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ptr_step;
    data_write |=> ptr == (($past(ptr) == PTR_LAST) ? PTR_RESET : $past(ptr) + 1'b1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step or wrap"); // [R1] [R2]
  property p_load_cycle;
    (start_prog || start_erase) |=> load_flag;
  endproperty
  a_load_cycle: assert property (p_load_cycle) else $error("load flag not set by write"); // [R4]
  property p_load_clear;
    load_cmd |=> !flags[BIT_LOAD];
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load flag not cleared"); // [R4]
  property p_start;
    start_prog |=> !flags[BIT_SUCCESS] && !flags[BIT_BUSY_N] && state == ST_PROGRAM;
  endproperty
  a_start: assert property (p_start) else $error("cycle start wrong"); // [R5]
  property p_bod_fail;
    (busy && inhibited) |=> (!idle || !success) ##1 1'b1;
  endproperty
  a_bod_fail: assert property (p_bod_fail) else $error("success after brown-out"); // [R7]
  property p_inhibit;
    inhibited |-> !flags[BIT_WRITE_INHIBIT] && !flags[BIT_BUSY_N];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit not reflected"); // [R6] [R8]
  property p_busy;
    !inhibited && $rose(busy) |-> !flags[BIT_BUSY_N] throughout (busy [*3]);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag high while programming"); // [R9]
  property p_poll;
    state == ST_PROGRAM |-> poll_byte == (last_byte ^ POLL_MASK);
  endproperty
  a_poll: assert property (p_poll) else $error("poll byte wrong while busy"); // [R10] [R12]
  property p_erase_poll;
    state == ST_ERASE |-> poll_byte == 8'h7f;
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("erase poll wrong"); // [R11]
  property p_upper;
    flags[7:4] == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper status bits set"); // [R13]
  property p_read;
    arvalid && arready |=> rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read not answered"); // [R14]

  c_program: cover property (state == ST_PROGRAM && count == CNT_LAST && !bod_seen && !inhibited);
  c_erase:   cover property (start_erase);
  c_bod:     cover property (busy && inhibited);
  c_wrap:    cover property (data_write && ptr == PTR_LAST);
endmodule

// ### bench/programmer_model.sv
// Bus master model of the external programmer on the AXI4-Lite side
`timescale 1ns/10ps
module programmer_model
  import page_program_status_pkg::*;
(
  input  wire logic                                      aclk,
  output logic                                           awvalid,
  input  wire logic                                      awready,
  output logic      [page_program_status_pkg::ADDR_W-1:0] awaddr,
  output logic                                           wvalid,
  input  wire logic                                      wready,
  output logic      [31:0]                               wdata,
  input  wire logic                                      bvalid,
  output logic                                           bready,
  input  wire logic [1:0]                                bresp,
  output logic                                           arvalid,
  input  wire logic                                      arready,
  output logic      [page_program_status_pkg::ADDR_W-1:0] araddr,
  input  wire logic                                      rvalid,
  output logic                                           rready,
  input  wire logic [31:0]                               rdata,
  input  wire logic [1:0]                                rresp
);
  logic        aw_hs, w_hs, b_hs, ar_hs, r_hs;
  logic [1:0]  resp_q;
  logic [31:0] data_q;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = '1;
    araddr = '1;
    wdata  = '1;
  end
  // Handshakes seen at each edge, read by the tasks just after it
  always @(posedge aclk) begin
    aw_hs <= awvalid && awready;
    w_hs  <= wvalid && wready;
    b_hs  <= bvalid && bready;
    ar_hs <= arvalid && arready;
    r_hs  <= rvalid && rready;
    if (bvalid && bready) resp_q <= bresp;
    if (rvalid && rready) begin
      data_q <= rdata;
      resp_q <= rresp;
    end
  end
  // Callers keep each location to one load per buffer fill
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      #1;
      if (aw_hs) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_hs) begin
        dd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    while (!b_hs) begin
      @(posedge aclk);
      #1;
    end
    // Response ready stays high between writes, so a following call never flips it back in one step
    r = resp_q;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      #1;
      if (ar_hs) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!r_hs);
    d = data_q;
    // Read data ready stays high between reads for the same reason
    r = resp_q;
  endtask
endmodule

// ### bench/test_page_program_status.sv
// Self-checking bench for the page programming status block
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_page_program_status;
  import page_program_status_pkg::*;
  logic              aclk, aresetn, brownout_detector;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  int                num_errors = 0;
  int                check_count = 0;
  int                i;
  programmer_model programmer_model_inst (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  page_program_status #(.prog_cycles(40)) page_program_status_inst (.aclk(aclk), .aresetn(aresetn),
    .brownout_detector(brownout_detector), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ====================================================================
  // Bus helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    programmer_model_inst.rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic wrc(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
    logic [1:0] r;
    programmer_model_inst.wr(a, v, r);
    `CHK(r, er)
  endtask
  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0;
    for (int k = 0; k < 100 && d[BIT_BUSY_N] !== 1'b1; k++) programmer_model_inst.rd(ADDR_FLAGS, d, r);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(5000);
    num_errors++;
    end_sim();
  end
  // ====================================================================
  // Tests
  initial begin
    aresetn = 1'b0;
    brownout_detector = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    rdc(ADDR_FLAGS, 32'h0b, RESP_OKAY);
    wrc(ADDR_FLAGS, 32'hf0, RESP_OKAY);
    rdc(ADDR_FLAGS, 32'h0b, RESP_OKAY);
    rdc(5'h14, 32'h0, RESP_SLVERR);
    wrc(5'h1c, 32'h1, RESP_SLVERR);
    $display("test reset done");
    wrc(ADDR_COMMAND, 32'h1 << CMD_LOAD_BUFFER, RESP_OKAY);
    rdc(ADDR_FLAGS, 32'h03, RESP_OKAY);
    wrc(ADDR_POINTER, 32'ha, RESP_OKAY);
    for (i = 0; i < PAGE_BYTES; i++) begin
      wrc(ADDR_DATA, 32'h30 + i, RESP_OKAY);
      if (i == 0) rdc(ADDR_POINTER, 32'hb, RESP_OKAY);
    end
    rdc(ADDR_POINTER, 32'ha, RESP_OKAY);
    rdc(ADDR_BUFFER, 32'h30, RESP_OKAY);
    wrc(ADDR_POINTER, 32'h3f, RESP_OKAY);
    rdc(ADDR_BUFFER, 32'h65, RESP_OKAY);
    rdc(ADDR_DATA, 32'h6f, RESP_OKAY);
    $display("test load done");
    wrc(ADDR_COMMAND, 32'h1 << CMD_PROGRAM, RESP_OKAY);
    rdc(ADDR_FLAGS, 32'h0a, RESP_OKAY);
    rdc(ADDR_DATA, {24'h0, 8'h6f ^ POLL_MASK}, RESP_OKAY);
    wait_idle();
    rdc(ADDR_FLAGS, 32'h0f, RESP_OKAY);
    rdc(ADDR_DATA, 32'h6f, RESP_OKAY);
    $display("test program done");
    wrc(ADDR_COMMAND, 32'h1 << CMD_ERASE, RESP_OKAY);
    rdc(ADDR_FLAGS, 32'h0a, RESP_OKAY);
    rdc(ADDR_DATA, {24'h0, ERASE_VALUE & ~POLL_MASK}, RESP_OKAY);
    wait_idle();
    rdc(ADDR_DATA, {24'h0, ERASE_VALUE}, RESP_OKAY);
    $display("test erase done");
    @(posedge aclk);
    brownout_detector <= 1'b1;
    cyc(8);
    rdc(ADDR_FLAGS, 32'h0c, RESP_OKAY);
    wrc(ADDR_COMMAND, 32'h1 << CMD_PROGRAM, RESP_OKAY);
    @(posedge aclk);
    brownout_detector <= 1'b0;
    cyc(8);
    rdc(ADDR_FLAGS, 32'h0f, RESP_OKAY);
    wrc(ADDR_COMMAND, 32'h1 << CMD_PROGRAM, RESP_OKAY);
    @(posedge aclk);
    brownout_detector <= 1'b1;
    cyc(6);
    rdc(ADDR_FLAGS, 32'h08, RESP_OKAY);
    @(posedge aclk);
    brownout_detector <= 1'b0;
    wait_idle();
    rdc(ADDR_FLAGS, 32'h0b, RESP_OKAY);
    $display("test brownout done");
    end_sim();
  end
endmodule
